// [hw/vcrl_pkg.sv]
// Purpose: Shared constants and state types of the voltage code link.
// Assumes: 8-bit codes, one code per serial frame.
// Notes:   Frame layout is a start bit, eight code bits, one ack slot.
`default_nettype none

package vcrl_pkg;

    // ****************************************************************
    // Code space
    // ****************************************************************
    localparam int         CODE_W          = 8;
    localparam logic [7:0] CODE_OFF        = 8'h00;
    localparam logic [7:0] CODE_LOWEST     = 8'h01;
    localparam logic [7:0] CODE_HIGHEST    = 8'hFF;
    localparam logic [7:0] THERMAL_BACKOFF = 8'h04;
    localparam int         LOAD_W          = 3;

    // ****************************************************************
    // Core-side timing counts
    // ****************************************************************
    localparam logic [7:0] SETTLE_CYCLES   = 8'h40;
    localparam logic [1:0] RETRY_LIMIT     = 2'h2;

    // ****************************************************************
    // Link framing
    // ****************************************************************
    localparam logic [3:0] FRAME_BITS      = 4'h9;
    localparam logic [3:0] ACK_SLOT_CYCLES = 4'h4;
    localparam logic       START_LEVEL     = 1'b0;
    localparam logic       ACK_LEVEL       = 1'b0;

    typedef enum logic [2:0] {
        CS_STRAP,
        CS_IDLE,
        CS_REQ,
        CS_RELEASE,
        CS_SETTLE
    } vcrl_core_state_t;

    typedef enum logic [1:0] {
        LS_IDLE,
        LS_SHIFT,
        LS_ACK,
        LS_DONE
    } vcrl_link_state_t;

endpackage : vcrl_pkg

`default_nettype wire

// [hw/vcrl_xfer_if.sv]
// Purpose: Request/acknowledge carrier between core and link domains.
// Assumes: Four-phase handshake; code held stable while req is high.
// Notes:   nack is valid whenever ack is high.
`default_nettype none

interface vcrl_xfer_if;
    logic       req;
    logic [7:0] code;
    logic       ack;
    logic       nack;

    modport core (output req, output code, input ack, input nack);
    modport link (input req, input code, output ack, output nack);
endinterface : vcrl_xfer_if

`default_nettype wire

// [hw/vcrl_sync.sv]
// Purpose: Two-flop level synchroniser, one bit per lane.
// Assumes: Multi-bit use only for static or handshake-held values.
// Notes:   First stage feeds nothing but the second stage.
`default_nettype none

module vcrl_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : vcrl_sync

`default_nettype wire

// [hw/vcrl_link_tx.sv]
// Purpose: Serialises one voltage code per handshake onto the link.
// Assumes: Runs on the link clock; open-drain clock and data pins.
// Notes:   Serial clock idles high; regulator samples on rising edge.
`default_nettype none

module vcrl_link_tx
    import vcrl_pkg::*;
(
    input  wire logic  link_clk_in,
    input  wire logic  rst_in,
    vcrl_xfer_if.link  xfer,
    input  wire logic  sdata_in,
    output logic       sdata_out,
    output logic       sdata_oe_out,
    output logic       sclk_out,
    output logic       sclk_oe_out
);
    vcrl_link_state_t state_q, state_d;
    logic [8:0] shreg_q, shreg_d;
    logic [3:0] cnt_q, cnt_d;
    logic       phase_q, phase_d;
    logic       sclk_oe_q, sclk_oe_d;
    logic       sdo_oe_q, sdo_oe_d;
    logic       ack_q, ack_d;
    logic       nack_q, nack_d;
    logic [1:0] raw_s;
    logic       req_s;
    logic       sdi_s;

    // Request is held by the core until ack, so two flops suffice
    vcrl_sync #(.WIDTH(2)) u_sync (
        .clk_in   (link_clk_in),
        .rst_in   (rst_in),
        .async_in ({xfer.req, sdata_in}),
        .sync_out (raw_s)
    );
    assign req_s = raw_s[1];
    assign sdi_s = raw_s[0];

    always_comb begin
        state_d   = state_q;
        shreg_d   = shreg_q;
        cnt_d     = cnt_q;
        phase_d   = phase_q;
        sclk_oe_d = 1'b0;
        sdo_oe_d  = sdo_oe_q;
        ack_d     = ack_q;
        nack_d    = nack_q;
        case (state_q)
            LS_IDLE: begin
                sdo_oe_d = 1'b0;
                if (req_s && !ack_q) begin
                    shreg_d = {START_LEVEL, xfer.code};
                    cnt_d   = 4'h0;
                    phase_d = 1'b0;
                    state_d = LS_SHIFT;
                end
            end
            LS_SHIFT: begin
                if (!phase_q) begin
                    // Data changes while clock is low
                    sclk_oe_d = 1'b1;
                    sdo_oe_d  = ~shreg_q[8];
                    phase_d   = 1'b1;
                end else begin
                    phase_d = 1'b0;
                    shreg_d = {shreg_q[7:0], 1'b1};
                    cnt_d   = cnt_q + 4'h1;
                    if (cnt_q == FRAME_BITS - 4'h1) begin
                        cnt_d   = 4'h0;
                        state_d = LS_ACK;
                    end
                end
            end
            LS_ACK: begin
                // Slot long enough to cover the pin synchroniser
                sdo_oe_d  = 1'b0;
                sclk_oe_d = 1'b1;
                cnt_d     = cnt_q + 4'h1;
                if (cnt_q == ACK_SLOT_CYCLES - 4'h1) begin
                    sclk_oe_d = 1'b0;
                    nack_d    = (sdi_s != ACK_LEVEL);
                    ack_d     = 1'b1;
                    state_d   = LS_DONE;
                end
            end
            LS_DONE: begin
                if (!req_s) begin
                    ack_d   = 1'b0;
                    state_d = LS_IDLE;
                end
            end
            default: state_d = LS_IDLE;
        endcase
    end

    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q   <= LS_IDLE;
            shreg_q   <= '1;
            cnt_q     <= 4'h0;
            phase_q   <= 1'b0;
            sclk_oe_q <= 1'b0;
            sdo_oe_q  <= 1'b0;
            ack_q     <= 1'b0;
            nack_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            shreg_q   <= shreg_d;
            cnt_q     <= cnt_d;
            phase_q   <= phase_d;
            sclk_oe_q <= sclk_oe_d;
            sdo_oe_q  <= sdo_oe_d;
            ack_q     <= ack_d;
            nack_q    <= nack_d;
        end
    end

    assign xfer.ack     = ack_q;
    assign xfer.nack    = nack_q;
    assign sdata_out    = 1'b0;
    assign sdata_oe_out = sdo_oe_q;
    assign sclk_out     = 1'b0;
    assign sclk_oe_out  = sclk_oe_q;
endmodule : vcrl_link_tx

`default_nettype wire

// [hw/vcrl_top.sv]
// Purpose: Chooses the core supply voltage code and sends it to the
//          regulator over the three-wire serial code link.
// Assumes: clk_in 200 MHz core clock; link_clk_in is the link clock.
// Notes:   Code moves one step at a time, except switch-off.
//
// How it works
// - Link is serial clock, data and alert
// - Each request is an 8-bit code
// - One bit is high level, zero low
// - Code follows temperature and load to save power
// - Default code is a per-device strap
// - Code steps only to adjacent values, except a switch-off request, which goes straight to 00h
`default_nettype none

module vcrl_top
    import vcrl_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              link_clk_in,
    input  wire logic [CODE_W-1:0] default_code_in,
    input  wire logic              enable_in,
    input  wire logic [LOAD_W-1:0] load_level_in,
    input  wire logic              temp_hot_in,
    input  wire logic              fail_clear_in,
    input  wire logic              serial_voltage_data_in,
    output logic                   serial_voltage_data_out,
    output logic                   serial_voltage_data_oe_out,
    output logic                   serial_voltage_clock_out,
    output logic                   serial_voltage_clock_oe_out,
    input  wire logic              regulator_alert_n_in,
    output logic [CODE_W-1:0]      current_code_out,
    output logic [CODE_W-1:0]      target_code_out,
    output logic                   busy_out,
    output logic                   fail_out,
    output logic                   alert_out
);

    // ****************************************************************
    // Code arithmetic
    // ****************************************************************

    // Saturating target from strap base, load and temperature
    function automatic logic [CODE_W-1:0] calc_target(
        input logic [CODE_W-1:0] base,
        input logic [LOAD_W-1:0] load,
        input logic              hot
    );
        logic [CODE_W:0] sum;
        sum = {1'b0, base} + {{(CODE_W+1-LOAD_W){1'b0}}, load};
        if (sum[CODE_W]) begin
            sum = {1'b0, CODE_HIGHEST};
        end
        if (hot) begin
            if (sum[CODE_W-1:0] > THERMAL_BACKOFF) begin
                sum = sum - {1'b0, THERMAL_BACKOFF};
            end else begin
                sum = {1'b0, CODE_LOWEST};
            end
        end
        if (sum[CODE_W-1:0] < CODE_LOWEST) begin
            sum = {1'b0, CODE_LOWEST};
        end
        return sum[CODE_W-1:0];
    endfunction : calc_target

    // One step from cur toward tgt; off request goes straight to 00h
    function automatic logic [CODE_W-1:0] step_toward(
        input logic [CODE_W-1:0] cur,
        input logic [CODE_W-1:0] tgt
    );
        logic [CODE_W-1:0] res;
        res = cur;
        if (tgt == CODE_OFF) begin
            res = CODE_OFF;
        end else if (cur == CODE_OFF) begin
            res = CODE_LOWEST;
        end else if (tgt > cur) begin
            res = cur + 8'h01;
        end else if (tgt < cur) begin
            res = cur - 8'h01;
        end
        return res;
    endfunction : step_toward

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [CODE_W+2:0] pins_s;
    logic [CODE_W-1:0] strap_s;
    logic              alert_s;
    logic              ack_s;
    logic              nack_s;

    vcrl_xfer_if xfer ();

    // Strap is static and nack changes with ack and then holds, so flops suffice
    vcrl_sync #(.WIDTH(CODE_W + 3)) u_pin_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({default_code_in, ~regulator_alert_n_in, xfer.ack,
                    xfer.nack}),
        .sync_out (pins_s)
    );
    assign strap_s = pins_s[CODE_W+2:3];
    assign alert_s = pins_s[2];
    assign ack_s   = pins_s[1];
    assign nack_s  = pins_s[0];

    // ****************************************************************
    // Link side
    // ****************************************************************
    vcrl_link_tx u_link (
        .link_clk_in  (link_clk_in),
        .rst_in       (rst_in),
        .xfer         (xfer),
        .sdata_in     (serial_voltage_data_in),
        .sdata_out    (serial_voltage_data_out),
        .sdata_oe_out (serial_voltage_data_oe_out),
        .sclk_out     (serial_voltage_clock_out),
        .sclk_oe_out  (serial_voltage_clock_oe_out)
    );

    // ****************************************************************
    // Core-side request sequencer
    // ****************************************************************
    vcrl_core_state_t  state_q, state_d;
    logic [CODE_W-1:0] base_q, base_d;
    logic [CODE_W-1:0] cur_q, cur_d;
    logic [CODE_W-1:0] send_q, send_d;
    logic [CODE_W-1:0] tgt_q, tgt_d;
    logic [1:0]        retry_q, retry_d;
    logic [7:0]        settle_q, settle_d;
    logic              req_q, req_d;
    logic              fail_q, fail_d;
    logic [1:0]        strap_wait_q, strap_wait_d;
    logic              alert_prev_q, alert_prev_d;
    logic              resend_q, resend_d;
    logic              alert_rise;
    logic              nack_seen;

    assign alert_rise = alert_s && !alert_prev_q;
    // nack stays stable until the next frame's ack
    assign nack_seen  = nack_s;

    always_comb begin
        state_d      = state_q;
        base_d       = base_q;
        cur_d        = cur_q;
        send_d       = send_q;
        retry_d      = retry_q;
        settle_d     = settle_q;
        req_d        = req_q;
        fail_d       = fail_q;
        strap_wait_d = strap_wait_q;
        alert_prev_d = alert_s;
        resend_d     = resend_q || alert_rise;
        tgt_d        = enable_in
                     ? calc_target(base_q, load_level_in, temp_hot_in)
                     : CODE_OFF;

        if (fail_clear_in) begin
            fail_d = 1'b0;
        end

        case (state_q)
            CS_STRAP: begin
                // Wait for the strap to pass the synchroniser
                strap_wait_d = strap_wait_q + 2'h1;
                if (strap_wait_q == 2'h2) begin
                    base_d  = strap_s;
                    cur_d   = CODE_OFF;
                    state_d = CS_IDLE;
                end
            end
            CS_IDLE: begin
                if (tgt_q != cur_q) begin
                    send_d   = step_toward(cur_q, tgt_q);
                    retry_d  = 2'h0;
                    req_d    = 1'b1;
                    resend_d = alert_rise;
                    state_d  = CS_REQ;
                end else if (resend_q) begin
                    // Alert: regulator wants the present code again
                    send_d   = cur_q;
                    retry_d  = 2'h0;
                    req_d    = 1'b1;
                    resend_d = alert_rise;
                    state_d  = CS_REQ;
                end
            end
            CS_REQ: begin
                if (ack_s) begin
                    req_d   = 1'b0;
                    state_d = CS_RELEASE;
                end
            end
            CS_RELEASE: begin
                if (!ack_s) begin
                    if (!nack_seen) begin
                        cur_d    = send_q;
                        settle_d = SETTLE_CYCLES;
                        state_d  = CS_SETTLE;
                    end else if (retry_q != RETRY_LIMIT) begin
                        retry_d = retry_q + 2'h1;
                        req_d   = 1'b1;
                        state_d = CS_REQ;
                    end else begin
                        // Regulator refused; hold last good code
                        fail_d  = 1'b1;
                        state_d = CS_IDLE;
                    end
                end
            end
            CS_SETTLE: begin
                // Let the rail reach the adjacent level before moving on
                settle_d = settle_q - 8'h01;
                if (settle_q == 8'h00) begin
                    state_d = CS_IDLE;
                end
            end
            default: state_d = CS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q      <= CS_STRAP;
            base_q       <= CODE_OFF;
            cur_q        <= CODE_OFF;
            send_q       <= CODE_OFF;
            tgt_q        <= CODE_OFF;
            retry_q      <= 2'h0;
            settle_q     <= 8'h00;
            req_q        <= 1'b0;
            fail_q       <= 1'b0;
            strap_wait_q <= 2'h0;
            alert_prev_q <= 1'b0;
            resend_q     <= 1'b0;
        end else begin
            state_q      <= state_d;
            base_q       <= base_d;
            cur_q        <= cur_d;
            send_q       <= send_d;
            tgt_q        <= tgt_d;
            retry_q      <= retry_d;
            settle_q     <= settle_d;
            req_q        <= req_d;
            fail_q       <= fail_d;
            strap_wait_q <= strap_wait_d;
            alert_prev_q <= alert_prev_d;
            resend_q     <= resend_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign xfer.req         = req_q;
    assign xfer.code        = send_q;
    assign current_code_out = cur_q;
    assign target_code_out  = tgt_q;
    assign busy_out         = (state_q != CS_IDLE);
    assign fail_out         = fail_q;
    assign alert_out        = alert_s;

endmodule : vcrl_top

`default_nettype wire

// [verif/vcrl_top_properties.sv]
// Purpose: Concurrent checks on the ports of the voltage code link top.
// Assumes: Bound to vcrl_top; rst_in resets both clock domains.
// Notes:   Frame shape is checked on the link clock.
`default_nettype none

module vcrl_top_properties
    import vcrl_pkg::*;
(
    input wire logic              clk_in,
    input wire logic              rst_in,
    input wire logic              link_clk_in,
    input wire logic              enable_in,
    input wire logic              regulator_alert_n_in,
    input wire logic              serial_voltage_data_out,
    input wire logic              serial_voltage_data_oe_out,
    input wire logic              serial_voltage_clock_out,
    input wire logic              serial_voltage_clock_oe_out,
    input wire logic [CODE_W-1:0] current_code_out,
    input wire logic [CODE_W-1:0] target_code_out,
    input wire logic              busy_out,
    input wire logic              alert_out
);
    sequence s_link_idle;
        !serial_voltage_clock_oe_out [*3];
    endsequence
    sequence s_clk_low_run;
        serial_voltage_clock_oe_out [*4];
    endsequence

    chk_pins_open_drain: assert property (
        @(posedge link_clk_in) disable iff (rst_in)
        !serial_voltage_data_out && !serial_voltage_clock_out)
        else $error("open-drain pin driven high");
    chk_frame_start_low: assert property (
        @(posedge link_clk_in) disable iff (rst_in)
        s_link_idle ##1 serial_voltage_clock_oe_out
        |-> serial_voltage_data_oe_out)
        else $error("frame start bit not low");
    chk_clock_low_bound: assert property (
        @(posedge link_clk_in) disable iff (rst_in)
        s_clk_low_run |=> !serial_voltage_clock_oe_out)
        else $error("serial clock held low too long");
    chk_data_clock_low: assert property (
        @(posedge link_clk_in) disable iff (rst_in)
        $changed(serial_voltage_data_oe_out) |-> serial_voltage_clock_oe_out)
        else $error("data moved while serial clock high");
    chk_code_step_adjacent: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $changed(current_code_out) |-> current_code_out == CODE_OFF
        || current_code_out == $past(current_code_out) + 8'h01
        || current_code_out == $past(current_code_out) - 8'h01)
        else $error("code jumped more than one step");
    chk_off_target: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!enable_in) [*3] |-> target_code_out == CODE_OFF)
        else $error("target not off while disabled");
    chk_settle_busy: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $changed(current_code_out) |-> busy_out [*8])
        else $error("no settle time after code change");
    chk_alert_sync: assert property (
        @(posedge clk_in) disable iff (rst_in)
        alert_out == !$past(regulator_alert_n_in, 2))
        else $error("alert not two cycles behind pin");
endmodule : vcrl_top_properties

bind vcrl_top vcrl_top_properties vcrl_top_properties_inst (
    .clk_in, .rst_in, .link_clk_in, .enable_in, .regulator_alert_n_in,
    .serial_voltage_data_out, .serial_voltage_data_oe_out,
    .serial_voltage_clock_out, .serial_voltage_clock_oe_out,
    .current_code_out, .target_code_out, .busy_out, .alert_out
);

`default_nettype wire

// [verif/vcrl_reg_model.sv]
// Purpose: Behavioural regulator at the far end of the code link.
// Assumes: Both lines pulled up; data sampled on clock rising edge.
// Notes:   Ack can be withheld to drive the nack path.
`default_nettype none

module vcrl_reg_model #(
    parameter int MAX_MV = 3040
) (
    input  wire logic   rst_in,
    input  wire logic   sclk_in,
    input  wire logic   sdata_in,
    input  wire logic   ack_en_in,
    output logic        sdata_oe_out,
    output logic [7:0]  code_out,
    output logic        start_out,
    output logic [15:0] frames_out,
    output logic        out_on_out
);
    int         nbits;
    int         mv;
    logic [8:0] shift;

    // Start bit, eight code bits MSB first, then the ack edge
    always @(posedge sclk_in or posedge rst_in) begin
        if (rst_in) begin
            nbits = 0;
            frames_out = 16'h0000;
            out_on_out = 1'b0;
            sdata_oe_out <= 1'b0;
        end else if (nbits < 9) begin
            shift = {shift[7:0], sdata_in};
            nbits++;
        end else begin
            nbits = 0;
            code_out = shift[7:0];
            start_out = shift[8];
            mv = (code_out == 8'h00) ? 0 : 490 + 10 * int'(code_out);
            out_on_out = (mv != 0) && (mv <= MAX_MV);
            sdata_oe_out <= #40 1'b0;
            frames_out++;
        end
    end

    // Ack held from slot start until past the sync stages
    always @(negedge sclk_in) begin
        if (nbits == 9) sdata_oe_out <= ack_en_in;
    end
endmodule : vcrl_reg_model

`default_nettype wire

// [verif/vcrl_top_tb.sv]
// Purpose: Self-checking bench for the voltage code link top.
// Assumes: Regulator model on pulled-up open-drain lines.
// Notes:   Expected frame codes queue up; a monitor pops them.
`default_nettype none

module vcrl_top_tb
    import vcrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk_in, rst_in, link_clk_in, enable_in;
    logic              temp_hot_in, fail_clear_in, alert_n, ack_en;
    logic [CODE_W-1:0] strap, cur, tgt, start_code;
    logic [LOAD_W-1:0] load;
    logic              d_oe, c_oe, r_oe, busy, fail, start, on;
    logic              sdata_w, sclk_w;
    logic [7:0]        code;
    logic [15:0]       frames;
    logic [7:0]        exp_q[$];
    int                fails, total_checks;
    logic [31:0]       seed;

    assign sclk_w  = ~c_oe;
    assign sdata_w = ~(d_oe | r_oe);

    vcrl_top vcrl_top_inst (
        .clk_in, .rst_in, .link_clk_in, .default_code_in(strap),
        .enable_in, .load_level_in(load), .temp_hot_in, .fail_clear_in,
        .serial_voltage_data_in(sdata_w), .serial_voltage_data_out(),
        .serial_voltage_data_oe_out(d_oe), .serial_voltage_clock_out(),
        .serial_voltage_clock_oe_out(c_oe), .regulator_alert_n_in(alert_n),
        .current_code_out(cur), .target_code_out(tgt), .busy_out(busy),
        .fail_out(fail), .alert_out()
    );
    vcrl_reg_model vcrl_reg_model_inst (
        .rst_in, .sclk_in(sclk_w), .sdata_in(sdata_w), .ack_en_in(ack_en),
        .sdata_oe_out(r_oe), .code_out(code), .start_out(start),
        .frames_out(frames), .out_on_out(on)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic conclude();
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge clk_in);
        #1;
    endtask : tick

    task automatic push_walk(input logic [7:0] from, input logic [7:0] to);
        logic [7:0] c;
        c = from;
        while (c != to) begin
            c = (to > c) ? c + 8'h01 : c - 8'h01;
            exp_q.push_back(c);
        end
    endtask : push_walk

    // Bounded wait; waits for fail instead of idle when asked
    task automatic wait_done(input logic for_fail);
        int n;
        n = 0;
        while ((exp_q.size() != 0 || (for_fail ? fail !== 1'b1
                : busy !== 1'b0)) && n < 4000) begin
            tick();
            n++;
        end
        if (n == 4000) begin
            fails++;
            $display("wrong value at %0t: wait ran out", $time);
        end
    endtask : wait_done

    always @(frames) begin
        if (frames != 16'h0000) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("wrong value at %0t: frame %h unexpected", $time,
                         code);
            end else begin
                check(code, exp_q.pop_front());
            end
            check({7'h00, start}, 8'h00);
        end
    end

    // ****************************************************************
    // Clocks, watchdog, stimulus
    // ****************************************************************
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #3;
        forever #16 link_clk_in = ~link_clk_in;
    end
    initial begin
        #100000;
        fails++;
        conclude();
    end

    initial begin
        seed = xs(32'h5999);
        strap = 8'h02 + {6'h00, seed[1:0]};
        seed = xs(seed);
        {rst_in, enable_in, temp_hot_in, fail_clear_in} = 4'h C;
        {alert_n, ack_en, load} = 5'h18;
        repeat (5) @(posedge clk_in);
        #1 rst_in = 1'b0;
        push_walk(8'h00, strap);
        wait_done(1'b0);
        check(cur, strap);
        load = {1'b0, seed[1:0]};
        start_code = strap + {5'h00, load};
        push_walk(strap, start_code);
        wait_done(1'b0);
        check(tgt, start_code);
        temp_hot_in = 1'b1;
        push_walk(start_code, (start_code > 8'h04) ?
                  start_code - THERMAL_BACKOFF : 8'h01);
        wait_done(1'b0);
        check(cur, (start_code > 8'h04) ?
              start_code - THERMAL_BACKOFF : CODE_LOWEST);
        alert_n = 1'b0;
        exp_q.push_back(cur);
        repeat (4) tick();
        alert_n = 1'b1;
        wait_done(1'b0);
        enable_in = 1'b0;
        exp_q.push_back(CODE_OFF);
        wait_done(1'b0);
        check(cur, CODE_OFF);
        ack_en = 1'b0;
        enable_in = 1'b1;
        repeat (3) exp_q.push_back(CODE_LOWEST);
        wait_done(1'b1);
        check(cur, CODE_OFF);
        fail_clear_in = 1'b1;
        tick();
        fail_clear_in = 1'b0;
        conclude();
    end
endmodule : vcrl_top_tb

`default_nettype wire
